/* File: hdl/rivm_pkg.sv */
package rivm_pkg;

  // ----------------------------------------------------------------
  // vector table geometry
  // ----------------------------------------------------------------
  localparam int unsigned SRC_COUNT    = 16;   // interrupt sources
  localparam int unsigned VEC_COUNT    = 17;   // reset plus sources
  localparam int unsigned OFS_W        = 5;    // width of a vector offset
  localparam int unsigned IDX_W        = 4;    // width of a source index
  localparam int unsigned ADDR_W_DEF   = 12;   // default program-counter width (words)

  // reset vector when not relocated
  localparam logic [OFS_W-1:0] OFS_RESET = 5'h00;

  // per-source vector offsets, in table order
  localparam logic [OFS_W-1:0] OFS_EXT_ZERO      = 5'h01;
  localparam logic [OFS_W-1:0] OFS_EXT_ONE       = 5'h02;
  localparam logic [OFS_W-1:0] OFS_WIDE_CAPTURE  = 5'h03;
  localparam logic [OFS_W-1:0] OFS_WIDE_MATCH_A  = 5'h04;
  localparam logic [OFS_W-1:0] OFS_WIDE_MATCH_B  = 5'h05;
  localparam logic [OFS_W-1:0] OFS_WIDE_OVERFLOW = 5'h06;
  localparam logic [OFS_W-1:0] OFS_BYTE_OVERFLOW = 5'h07;
  localparam logic [OFS_W-1:0] OFS_SPI_DONE      = 5'h08;
  localparam logic [OFS_W-1:0] OFS_UART_RX_DONE  = 5'h09;
  localparam logic [OFS_W-1:0] OFS_UART_EMPTY    = 5'h0A;
  localparam logic [OFS_W-1:0] OFS_UART_TX_DONE  = 5'h0B;
  localparam logic [OFS_W-1:0] OFS_COMPARATOR    = 5'h0C;
  localparam logic [OFS_W-1:0] OFS_EXT_TWO       = 5'h0D;
  localparam logic [OFS_W-1:0] OFS_BYTE_MATCH    = 5'h0E;
  localparam logic [OFS_W-1:0] OFS_EEPROM_READY  = 5'h0F;
  localparam logic [OFS_W-1:0] OFS_SELF_PROG_RDY = 5'h10;

  // ----------------------------------------------------------------
  // control and fuse encodings
  // ----------------------------------------------------------------
  localparam int unsigned  CTRL_W         = 8;
  localparam int unsigned  CTRL_VSEL_BIT  = 1;     // vector-select bit position
  localparam logic         FUSE_PROGRAMMED = 1'b0; // fuse: 0 programmed, 1 not

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned  SYNC_STAGES    = 2;     // pin synchroniser depth
  localparam logic [1:0]   SETTLE_CYCLES  = 2'h2;  // wait for synced straps

  // ----------------------------------------------------------------
  // dispatch state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SETTLE   = 4'h1,
    ST_RESET    = 4'h2,
    ST_IDLE     = 4'h4,
    ST_DISPATCH = 4'h8
  } rivm_state_t;

endpackage

/* File: hdl/rivm_sel_if.sv */
// carries pending requests to the priority picker and the winner back
interface rivm_sel_if;
  logic [rivm_pkg::SRC_COUNT-1:0] req;
  logic                           found;
  logic [rivm_pkg::IDX_W-1:0]     idx;

  modport picker (input req, output found, output idx);
  modport user   (output req, input found, input idx);
endinterface

/* File: hdl/rivm_prio_pick.sv */
// lowest source index has the highest priority
module rivm_prio_pick (
  // request set and winner
  rivm_sel_if.picker sel
);

  // ----------------------------------------------------------------
  // priority scan
  // ----------------------------------------------------------------
  // scan from the top down so the lowest set index is the last to win
  always_comb begin
    sel.found = 1'b0;
    sel.idx   = '0;
    for (int i = rivm_pkg::SRC_COUNT - 1; i >= 0; i--) begin
      if (sel.req[i]) begin
        sel.found = 1'b1;
        sel.idx   = rivm_pkg::IDX_W'(i);
      end
    end
  end

endmodule

/* File: hdl/rivm_top.sv */
// ----------------------------------------------------------------
// reset and interrupt vector mapper
// ----------------------------------------------------------------
// Overview of operation
// R1 - any chip reset starts execution at the reset vector, $000 unless relocated
// R2 - external request zero goes to $001, external request one to $002
// R3 - wide timer capture goes to $003, its match A to $004
// R4 - wide timer match B $005, overflow $006; byte timer overflow $007, match $00E
// R5 - serial done $008; uart receive $009, data empty $00A, transmit $00B
// R6 - comparator event goes to $00C, external request two to $00D
// R7 - eeprom ready goes to $00F, self-program ready to $010; seventeen vectors
// R8 - vector select set moves interrupt vectors, not reset, into boot section
// R9 - relocated interrupt address is base offset plus boot section start
// R10 - programmed boot-reset fuse puts the reset vector at the boot reset address
// R11 - reset at $0000 or boot address; interrupt base $0001 or boot plus $0001
// R12 - fuse value one means unprogrammed, zero means programmed
// R13 - vector select clear keeps interrupt vectors at application flash start
// R14 - accepted interrupt loads the program counter with its single-word vector
// R15 - boot reset address and boot section start arrive as inputs
module rivm_top #(
  parameter int unsigned ADDR_W = rivm_pkg::ADDR_W_DEF
) (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // external interrupt pins
  input  wire logic                           ext_irq_zero,
  input  wire logic                           ext_irq_one,
  input  wire logic                           ext_irq_two,
  // on-chip peripheral requests, core clock
  input  wire logic                           wide_timer_capture_irq,
  input  wire logic                           wide_timer_match_a_irq,
  input  wire logic                           wide_timer_match_b_irq,
  input  wire logic                           wide_timer_overflow_irq,
  input  wire logic                           byte_timer_overflow_irq,
  input  wire logic                           byte_timer_match_irq,
  input  wire logic                           spi_done_irq,
  input  wire logic                           uart_rx_done_irq,
  input  wire logic                           uart_empty_irq,
  input  wire logic                           uart_tx_done_irq,
  input  wire logic                           comparator_irq,
  input  wire logic                           eeprom_ready_irq,
  input  wire logic                           self_program_ready_irq,
  // fuses and boot-size configuration
  input  wire logic                           boot_reset_fuse,
  input  wire logic [ADDR_W-1:0]              boot_reset_addr,
  input  wire logic [ADDR_W-1:0]              boot_section_start,
  // control register contents, core clock
  input  wire logic [rivm_pkg::CTRL_W-1:0]    general_irq_control_reg,
  // core fetch side
  input  wire logic                           irq_global_enable,
  input  wire logic                           pc_load_ready,
  output logic                                pc_load_valid,
  output logic [ADDR_W-1:0]                   pc_load_addr,
  output logic                                pc_load_is_reset,
  output logic [rivm_pkg::SRC_COUNT-1:0]      irq_ack
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the table must fit in the counter with room for the boot section
  if (ADDR_W < rivm_pkg::OFS_W || ADDR_W > 22) begin : g_bad_width
    $error("rivm_top: ADDR_W out of range");
  end

  // the offset table below is written out for exactly this geometry
  if (rivm_pkg::VEC_COUNT != rivm_pkg::SRC_COUNT + 1) begin : g_bad_count
    $error("rivm_top: vector count must be sources plus reset");
  end

  // every source index must be reachable, and no index may be spare
  if ((1 << rivm_pkg::IDX_W) != rivm_pkg::SRC_COUNT) begin : g_bad_index
    $error("rivm_top: index width does not match the source count");
  end

  // the last offset must still fit in an offset field
  if (rivm_pkg::VEC_COUNT > (1 << rivm_pkg::OFS_W)) begin : g_bad_offset
    $error("rivm_top: offset width too small for the table");
  end

  // the chain below is written for two stages; a zero settle count
  // would wrap the compare to 3 and hold the settle state four cycles
  if (rivm_pkg::SYNC_STAGES != 2 || rivm_pkg::SETTLE_CYCLES == 2'h0) begin : g_bad_sync
    $error("rivm_top: synchroniser depth or settle count unsupported");
  end

  // ----------------------------------------------------------------
  // offset lookup
  // ----------------------------------------------------------------
  // shared by the dispatch path for both base selections
  function automatic logic [rivm_pkg::OFS_W-1:0] src_offset(
    input logic [rivm_pkg::IDX_W-1:0] idx
  );
    logic [rivm_pkg::OFS_W-1:0] ofs;
    ofs = rivm_pkg::OFS_RESET;
    case (idx)
      4'h0:    ofs = rivm_pkg::OFS_EXT_ZERO;      // R2
      4'h1:    ofs = rivm_pkg::OFS_EXT_ONE;       // R2
      4'h2:    ofs = rivm_pkg::OFS_WIDE_CAPTURE;  // R3
      4'h3:    ofs = rivm_pkg::OFS_WIDE_MATCH_A;  // R3
      4'h4:    ofs = rivm_pkg::OFS_WIDE_MATCH_B;  // R4
      4'h5:    ofs = rivm_pkg::OFS_WIDE_OVERFLOW; // R4
      4'h6:    ofs = rivm_pkg::OFS_BYTE_OVERFLOW; // R4
      4'h7:    ofs = rivm_pkg::OFS_SPI_DONE;      // R5
      4'h8:    ofs = rivm_pkg::OFS_UART_RX_DONE;  // R5
      4'h9:    ofs = rivm_pkg::OFS_UART_EMPTY;    // R5
      4'hA:    ofs = rivm_pkg::OFS_UART_TX_DONE;  // R5
      4'hB:    ofs = rivm_pkg::OFS_COMPARATOR;    // R6
      4'hC:    ofs = rivm_pkg::OFS_EXT_TWO;       // R6
      4'hD:    ofs = rivm_pkg::OFS_BYTE_MATCH;    // R4
      4'hE:    ofs = rivm_pkg::OFS_EEPROM_READY;  // R7
      4'hF:    ofs = rivm_pkg::OFS_SELF_PROG_RDY; // R7
      default: ofs = rivm_pkg::OFS_RESET;
    endcase
    return ofs;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // external pins, fuse and boot-size straps come from outside the clock
  localparam int unsigned PIN_W = 4 + 2 * ADDR_W;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] next_pin_meta;
  logic [PIN_W-1:0] next_pin_sync;

  assign pin_raw = {ext_irq_zero, ext_irq_one, ext_irq_two, boot_reset_fuse,
                    boot_reset_addr, boot_section_start};

  // pin_meta is read by pin_sync alone
  always_comb begin
    next_pin_meta = pin_raw;
    next_pin_sync = pin_meta;
  end

  // no reset on purpose: the chain keeps sampling while rst is held, so
  // the straps are settled before the settle count starts; a cleared
  // chain would read as a programmed fuse with a zero boot address
  always_ff @(posedge sys_clk) begin
    pin_meta <= next_pin_meta;
    pin_sync <= next_pin_sync;
  end

  logic              s_ext_zero;
  logic              s_ext_one;
  logic              s_ext_two;
  logic              s_fuse;
  logic [ADDR_W-1:0] s_boot_reset;
  logic [ADDR_W-1:0] s_boot_start;

  assign {s_ext_zero, s_ext_one, s_ext_two, s_fuse, s_boot_reset, s_boot_start} = pin_sync;

  // ----------------------------------------------------------------
  // address selection
  // ----------------------------------------------------------------
  logic              fuse_programmed;
  logic              vec_relocated;
  logic [ADDR_W-1:0] reset_addr;
  logic [ADDR_W-1:0] irq_base;

  assign fuse_programmed = (s_fuse == rivm_pkg::FUSE_PROGRAMMED);                // R12
  assign vec_relocated   = general_irq_control_reg[rivm_pkg::CTRL_VSEL_BIT];     // R13

  // reset vector ignores the vector-select bit on purpose
  assign reset_addr = fuse_programmed ? s_boot_reset                              // R10 R15
                                      : ADDR_W'(rivm_pkg::OFS_RESET);            // R1 R11
  // relocation adds the boot start; cleared select keeps application flash
  assign irq_base   = vec_relocated ? s_boot_start : '0;                         // R8 R13 R15

  // ----------------------------------------------------------------
  // request gathering and priority pick
  // ----------------------------------------------------------------
  rivm_sel_if sel ();

  assign sel.req = {self_program_ready_irq, eeprom_ready_irq, byte_timer_match_irq,
                    s_ext_two, comparator_irq, uart_tx_done_irq, uart_empty_irq,
                    uart_rx_done_irq, spi_done_irq, byte_timer_overflow_irq,
                    wide_timer_overflow_irq, wide_timer_match_b_irq,
                    wide_timer_match_a_irq, wide_timer_capture_irq,
                    s_ext_one, s_ext_zero};

  rivm_prio_pick u_pick (
    .sel (sel.picker)
  );

  logic [ADDR_W-1:0] win_addr;

  // consecutive single-word slots above the chosen base
  assign win_addr = irq_base + ADDR_W'(src_offset(sel.idx));                     // R9 R11 R14

  // ----------------------------------------------------------------
  // dispatch state machine
  // ----------------------------------------------------------------
  rivm_pkg::rivm_state_t              state;
  rivm_pkg::rivm_state_t              next_state;
  logic [1:0]                         settle_cnt;
  logic [1:0]                         next_settle_cnt;
  logic                               next_pc_load_valid;
  logic [ADDR_W-1:0]                  next_pc_load_addr;
  logic                               next_pc_load_is_reset;
  logic [rivm_pkg::SRC_COUNT-1:0]     next_irq_ack;
  logic [rivm_pkg::IDX_W-1:0]         serve_idx;
  logic [rivm_pkg::IDX_W-1:0]         next_serve_idx;

  // the winner is frozen while the core has not taken it, so a later
  // higher-priority request cannot change an address already offered
  always_comb begin
    next_state            = state;
    next_settle_cnt       = settle_cnt;
    next_pc_load_valid    = pc_load_valid;
    next_pc_load_addr     = pc_load_addr;
    next_pc_load_is_reset = pc_load_is_reset;
    next_irq_ack          = '0;
    next_serve_idx        = serve_idx;
    case (state)
      rivm_pkg::ST_SETTLE: begin
        // straps need the synchroniser delay before they are trusted
        if (settle_cnt == rivm_pkg::SETTLE_CYCLES - 2'h1) begin
          next_state            = rivm_pkg::ST_RESET;
          next_pc_load_valid    = 1'b1;                                          // R1
          next_pc_load_addr     = reset_addr;                                    // R1 R10
          next_pc_load_is_reset = 1'b1;
        end else begin
          next_settle_cnt = settle_cnt + 2'h1;
        end
      end
      rivm_pkg::ST_RESET: begin
        if (pc_load_ready) begin
          next_state            = rivm_pkg::ST_IDLE;
          next_pc_load_valid    = 1'b0;
          next_pc_load_is_reset = 1'b0;
        end
      end
      rivm_pkg::ST_IDLE: begin
        if (irq_global_enable && sel.found) begin
          next_state         = rivm_pkg::ST_DISPATCH;
          next_pc_load_valid = 1'b1;                                             // R14
          next_pc_load_addr  = win_addr;                                         // R14
          next_serve_idx     = sel.idx;
        end
      end
      rivm_pkg::ST_DISPATCH: begin
        if (pc_load_ready) begin
          next_state              = rivm_pkg::ST_IDLE;
          next_pc_load_valid      = 1'b0;
          next_irq_ack[serve_idx] = 1'b1;                                        // R14
        end
      end
      default: begin
        // an illegal code drops any offer rather than guess its kind
        next_state            = rivm_pkg::ST_IDLE;
        next_pc_load_valid    = 1'b0;
        next_pc_load_is_reset = 1'b0;
      end
    endcase
  end

  // every chip reset source arrives here as rst
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state            <= rivm_pkg::ST_SETTLE;                                   // R1
      settle_cnt       <= 2'h0;
      pc_load_valid    <= 1'b0;
      pc_load_addr     <= '0;
      pc_load_is_reset <= 1'b0;
      irq_ack          <= '0;
      serve_idx        <= '0;
    end else begin
      state            <= next_state;
      settle_cnt       <= next_settle_cnt;
      pc_load_valid    <= next_pc_load_valid;
      pc_load_addr     <= next_pc_load_addr;
      pc_load_is_reset <= next_pc_load_is_reset;
      irq_ack          <= next_irq_ack;
      serve_idx        <= next_serve_idx;
    end
  end

endmodule

/* File: tb/rivm_chk_props.sv */
module rivm_chk #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst,
  // straps and control
  input wire logic                           boot_reset_fuse,
  input wire logic [ADDR_W-1:0]              boot_reset_addr,
  input wire logic [ADDR_W-1:0]              boot_section_start,
  input wire logic [rivm_pkg::CTRL_W-1:0]    general_irq_control_reg,
  input wire logic                           irq_global_enable,
  // fetch side
  input wire logic                           pc_load_ready,
  input wire logic                           pc_load_valid,
  input wire logic [ADDR_W-1:0]              pc_load_addr,
  input wire logic                           pc_load_is_reset,
  input wire logic [rivm_pkg::SRC_COUNT-1:0] irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] ack_ofs;
  // ----------------------------------------------------------------
  // offset of the served source, one above its index
  // ----------------------------------------------------------------
  always_comb begin
    ack_ofs = '0;
    for (int i = 0; i < rivm_pkg::SRC_COUNT; i++) begin
      if (irq_ack[i]) begin
        ack_ofs = ADDR_W'(i + 1);
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ack is a lone pulse, never beside an open offer
  property p_ack_onehot;
    irq_ack != '0 |-> $onehot(irq_ack) && !pc_load_valid;
  endproperty
  a_ack_onehot: assert property (p_ack_onehot)
    else $error("ack not one-hot or seen with valid");
  property p_hold;
    pc_load_valid && !pc_load_ready |=> pc_load_valid && $stable(pc_load_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offer changed before acceptance");
  property p_drop;
    pc_load_valid && pc_load_ready |=> !pc_load_valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("offer stayed after acceptance");
  // straps only change under reset, so the live values are the synced ones
  property p_reset_addr;
    pc_load_valid && pc_load_is_reset |-> pc_load_addr ==
      (boot_reset_fuse == rivm_pkg::FUSE_PROGRAMMED ? boot_reset_addr : '0);
  endproperty
  a_reset_addr: assert property (p_reset_addr)
    else $error("wrong reset vector address");
  property p_reset_first;
    $fell(rst) |-> ##[1:4] (pc_load_valid && pc_load_is_reset);
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("no reset vector after release");
  property p_ack_cause;
    irq_ack != '0 |-> $past(pc_load_valid && pc_load_ready && !pc_load_is_reset);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without an accepted interrupt offer");
  property p_irq_addr;
    irq_ack != '0 |-> $past(pc_load_addr) == ack_ofs +
      ($past(general_irq_control_reg[rivm_pkg::CTRL_VSEL_BIT]) ? boot_section_start : '0);
  endproperty
  a_irq_addr: assert property (p_irq_addr)
    else $error("interrupt vector address wrong for served source");
  property p_take_enable;
    $rose(pc_load_valid) && !pc_load_is_reset |-> $past(irq_global_enable);
  endproperty
  a_take_enable: assert property (p_take_enable)
    else $error("interrupt taken while globally disabled");
  property p_reset_flag;
    pc_load_is_reset |-> pc_load_valid;
  endproperty
  a_reset_flag: assert property (p_reset_flag)
    else $error("reset flag without valid");
  c_reset_prog: cover property (pc_load_is_reset && boot_reset_fuse == 1'b0);
  c_relocated: cover property (irq_ack != '0 && general_irq_control_reg[1]);
  c_stall: cover property (pc_load_valid && !pc_load_ready [*3]);
endmodule

bind rivm_top rivm_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .rst, .boot_reset_fuse,
  .boot_reset_addr, .boot_section_start, .general_irq_control_reg, .irq_global_enable,
  .pc_load_ready, .pc_load_valid, .pc_load_addr, .pc_load_is_reset, .irq_ack);

/* File: tb/rivm_core_model.sv */
module rivm_core_model (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // fetch handshake
  input wire logic       pc_load_valid,
  output logic           pc_load_ready,
  // cycles the core stalls before it takes an offer
  input wire logic [3:0] stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // ready is combinational so a zero stall accepts in the offer's first cycle
  assign pc_load_ready = pc_load_valid && (wait_cnt >= stall);
  // count the cycles an offer has waited
  always_ff @(posedge sys_clk) begin
    if (rst || !pc_load_valid || pc_load_ready) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] src = 16'h0000;
  logic        fuse = 1'b1;
  logic [11:0] braddr = 12'h000;
  logic [11:0] bsstart = 12'h000;
  logic [7:0]  ctrl = 8'h00;
  logic        gen = 1'b0;
  logic [3:0]  stall = 4'h0;
  logic        valid, is_rst, ready;
  logic [11:0] addr;
  logic [15:0] ack;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // ----------------------------------------------------------------
  // design, core model, clock and hang guard
  // ----------------------------------------------------------------
  rivm_top #(.ADDR_W(12)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .ext_irq_zero(src[0]), .ext_irq_one(src[1]), .wide_timer_capture_irq(src[2]),
    .wide_timer_match_a_irq(src[3]), .wide_timer_match_b_irq(src[4]),
    .wide_timer_overflow_irq(src[5]), .byte_timer_overflow_irq(src[6]),
    .spi_done_irq(src[7]), .uart_rx_done_irq(src[8]), .uart_empty_irq(src[9]),
    .uart_tx_done_irq(src[10]), .comparator_irq(src[11]), .ext_irq_two(src[12]),
    .byte_timer_match_irq(src[13]), .eeprom_ready_irq(src[14]),
    .self_program_ready_irq(src[15]), .boot_reset_fuse(fuse), .boot_reset_addr(braddr),
    .boot_section_start(bsstart), .general_irq_control_reg(ctrl), .irq_global_enable(gen),
    .pc_load_ready(ready), .pc_load_valid(valid), .pc_load_addr(addr),
    .pc_load_is_reset(is_rst), .irq_ack(ack));
  rivm_core_model u_core (.sys_clk(sys_clk), .rst(rst), .pc_load_valid(valid),
    .pc_load_ready(ready), .stall(stall));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // a run well past the longest sequence means something hung
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // expectations and shared tasks
  // ----------------------------------------------------------------
  function automatic int lowest(input logic [15:0] m);
    int r;
    r = 0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = i;
      end
    end
    return r;
  endfunction
  function automatic logic [15:0] exp_irq(input int idx, input logic vs);
    return (vs ? {4'h0, bsstart} : 16'h0000) + 16'(idx + 1);
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait until an offer meets ready, seen mid-cycle
  task automatic wait_offer();
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (!(valid === 1'b1 && ready === 1'b1) && k < 40);
    chk("handshake", 16'h0001, {15'h0, valid & ready});
  endtask
  task automatic do_reset(input logic f);
    @(posedge sys_clk);
    rst <= 1'b1;
    gen <= 1'b0;
    src <= 16'h0000;
    fuse <= f;
    braddr <= 12'($urandom) & 12'hFE0;
    bsstart <= 12'($urandom) & 12'hFE0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wait_offer();
    chk("reset flag", 16'h0001, {15'h0, is_rst});
    chk("reset addr", f ? 16'h0000 : {4'h0, braddr}, {4'h0, addr});
    @(posedge sys_clk);
  endtask
  // raise a set of sources, then serve them; the core drops its enable on entry
  task automatic run_batch(input logic [15:0] mask, input logic vs, input logic [3:0] st);
    logic [15:0] left;
    int          idx;
    left = mask;
    @(posedge sys_clk);
    src <= mask;
    stall <= st;
    ctrl <= (8'($urandom) & 8'hFD) | {6'h00, vs, 1'b0};
    repeat (4) @(negedge sys_clk);
    chk("held off", 16'h0000, {15'h0, valid});
    @(posedge sys_clk);
    gen <= 1'b1;
    while (left != 16'h0000) begin
      idx = lowest(left);
      wait_offer();
      chk("irq flag", 16'h0000, {15'h0, is_rst});
      chk("irq addr", exp_irq(idx, vs), {4'h0, addr});
      @(posedge sys_clk);
      src[idx] <= 1'b0;
      gen <= 1'b0;
      left[idx] = 1'b0;
      @(negedge sys_clk);
      chk("ack", 16'h0001 << idx, ack);
      repeat (3) @(posedge sys_clk);
      gen <= 1'b1;
    end
    @(posedge sys_clk);
    gen <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(13));
    do_reset(1'b1);
    run_batch(16'hFFFF, 1'b0, 4'h0);
    run_batch(16'hFFFF, 1'b1, 4'h2);
    do_reset(1'b0);
    run_batch(16'h9001, 1'b1, 4'h0);
    run_batch(16'h1003, 1'b0, 4'h1);
    for (int t = 0; t < 12; t++) begin
      if (t % 4 == 0) begin
        do_reset(1'($urandom));
      end
      run_batch(16'($urandom), 1'($urandom), 4'($urandom % 5));
    end
    complete_run();
  end
endmodule
